// ===== rtl/aic_params.svh
// Constants for the accumulator, error-clear and interrupt command executor
`ifndef AIC_PARAMS_SVH
`define AIC_PARAMS_SVH

// Opcodes
`define AIC_OP_ACCU_TO_AXIS 8'h22
`define AIC_OP_ACCU_TO_GLOBAL 8'h23
`define AIC_OP_CLEAR_ERR 8'h24
`define AIC_OP_IRQ_ENABLE 8'h19
`define AIC_OP_IRQ_MASK 8'h1A
`define AIC_OP_IRQ_BIND 8'h25

// Type and bank codes
`define AIC_TYPE_ALL_IRQ 8'hFF
`define AIC_TYPE_CLEAR_ALL 8'h00
`define AIC_NUM_ERR_FLAGS 5
`define AIC_BANK_GLOBAL0 8'h00
`define AIC_BANK_USER 8'h02
`define AIC_BANK_GLOBAL3 8'h03

// Reply status codes
`define AIC_STAT_OK 8'h64
`define AIC_STAT_BAD_CSUM 8'h01
`define AIC_STAT_BAD_CMD 8'h02
`define AIC_STAT_BAD_TYPE 8'h03
`define AIC_STAT_BAD_VALUE 8'h04

// Frame layout
`define AIC_FRAME_BYTES 4'h9
`define AIC_REPLY_BYTES 4'h9

// Register byte offsets
`define AIC_REG_CTRL 8'h00
`define AIC_REG_ACCU 8'h04
`define AIC_REG_CMD_WORD 8'h08
`define AIC_REG_CMD_VALUE 8'h0C
`define AIC_REG_ERR_FLAGS 8'h10
`define AIC_REG_IRQ_GLOBAL 8'h14
`define AIC_REG_IRQ_EN 8'h18
`define AIC_REG_IRQ_HANDLER_BIND_CMD_SEL 8'h1C
`define AIC_REG_IRQ_HANDLER_BIND_CMD_DATA 8'h20
`define AIC_REG_UVAR_SEL 8'h24
`define AIC_REG_UVAR_DATA 8'h28
`define AIC_REG_EVT_STATUS 8'h2C
`define AIC_REG_EVT_MASK 8'h30
`define AIC_REG_LAST_STAT 8'h34

// Event bit positions
`define AIC_EVT_DONE 0
`define AIC_EVT_CSUM 1
`define AIC_EVT_REJECT 2
`define AIC_EVT_ERR 3
`define AIC_EVT_BITS 4

// Reset values
`define AIC_RST_WORD 32'h0000_0000
`define AIC_RST_BYTE 8'h00

`endif

// ===== rtl/aic_pkg.sv
// Types shared by the command executor files
package aic_pkg;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] typ;
        logic [7:0] bank;
        logic [31:0] value;
    } aic_cmd_t;

endpackage : aic_pkg

// ===== rtl/aic_frame_rx.sv
// Nine-byte command frame receiver with checksum check
`timescale 1ns/1ps
`include "aic_params.svh"

module aic_frame_rx import aic_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_rx_ready,
    input wire logic i_take,
    output logic o_frm_valid,
    output logic [63:0] o_frm_data,
    output logic o_csum_ok
);

    typedef struct packed {
        logic [3:0] cnt;
        logic [63:0] bytes;
        logic [7:0] sum;
        logic valid;
        logic ok;
        logic ready;
    } aic_rx_state_t;

    aic_rx_state_t s_r;
    aic_rx_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (s_r.valid && i_take) begin
            s_nxt.valid = 1'b0;
        end
        if (i_rx_valid && s_r.ready) begin
            if (s_r.cnt == `AIC_FRAME_BYTES - 4'h1) begin
                s_nxt.ok = (i_rx_data == s_r.sum);
                s_nxt.valid = 1'b1;
                s_nxt.cnt = 4'h0;
                s_nxt.sum = `AIC_RST_BYTE;
            end else begin
                s_nxt.bytes = {s_r.bytes[55:0], i_rx_data};
                s_nxt.sum = s_r.sum + i_rx_data;
                s_nxt.cnt = s_r.cnt + 4'h1;
            end
        end
        // Hold the line while a frame waits for the executor
        s_nxt.ready = ~s_nxt.valid;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rx_ready = s_r.ready;
    assign o_frm_valid = s_r.valid;
    assign o_frm_data = s_r.bytes;
    assign o_csum_ok = s_r.ok;

    AST_RX_STALL: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        s_r.valid |-> !s_r.ready)
        else $error("receiver ready while a frame is pending");

endmodule : aic_frame_rx

// ===== rtl/aic_reply_tx.sv
// Nine-byte reply sender
`timescale 1ns/1ps
`include "aic_params.svh"

module aic_reply_tx import aic_pkg::*; #(
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter logic [7:0] HOST_ADDR = 8'h02
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic [7:0] i_stat,
    input wire logic [7:0] i_op,
    input wire logic [31:0] i_value,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    output logic o_busy
);

    typedef struct packed {
        logic valid;
        logic [3:0] left;
        logic [71:0] bytes;
    } aic_tx_state_t;

    aic_tx_state_t s_r;
    aic_tx_state_t s_nxt;
    logic [7:0] csum;

    always_comb begin
        csum = MODULE_ADDR + HOST_ADDR + i_stat + i_op + i_value[31:24] + i_value[23:16]
            + i_value[15:8] + i_value[7:0];
        s_nxt = s_r;
        if (i_start && !s_r.valid) begin
            s_nxt.bytes = {MODULE_ADDR, HOST_ADDR, i_stat, i_op, i_value, csum};
            s_nxt.valid = 1'b1;
            s_nxt.left = `AIC_REPLY_BYTES - 4'h1;
        end else if (s_r.valid && i_tx_ready) begin
            if (s_r.left == 4'h0) begin
                s_nxt.valid = 1'b0;
            end else begin
                s_nxt.bytes = {s_r.bytes[63:0], `AIC_RST_BYTE};
                s_nxt.left = s_r.left - 4'h1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_tx_valid = s_r.valid;
    assign o_tx_data = s_r.bytes[71:64];
    assign o_busy = s_r.valid;

    AST_TX_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (s_r.valid && !i_tx_ready) |=> (s_r.valid && $stable(s_r.bytes)))
        else $error("reply byte changed while stalled");

endmodule : aic_reply_tx

// ===== rtl/aic_cmd_exec.sv
// Command executor: accumulator copies, error clear, interrupt enables and vectors
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "aic_params.svh"

// Function
// - Opcode 35 copies accumulator to global, bank 0/2/3
// - Bank 2 stores into indexed user variable
// - Opcode 36 clears error flags, type 0 all
// - Types 1..5 clear one error flag each
// - Opcode 25 sets the numbered interrupt enable
// - Interrupt 255 sets the global enable
// - Opcode 26 clears the numbered interrupt enable
// - Interrupt 255 clears the global enable
// - Opcode 37 stores handler address for interrupt
// - Later vector definition replaces the stored address
module aic_cmd_exec import aic_pkg::*; #(
    parameter int NUM_IRQ = 32,
    parameter int NUM_UVAR = 64,
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter logic [7:0] HOST_ADDR = 8'h02
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_rx_ready,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    input wire logic [4:0] i_err_set,
    output logic o_ap_wr,
    output logic [7:0] o_ap_idx,
    output logic [7:0] o_ap_motor,
    output logic [31:0] o_ap_data,
    output logic o_gp_wr,
    output logic [7:0] o_gp_bank,
    output logic [7:0] o_gp_idx,
    output logic [31:0] o_gp_data,
    output logic o_irq
);

    localparam int IW = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;
    localparam int UW = (NUM_UVAR > 1) ? $clog2(NUM_UVAR) : 1;

    if (NUM_IRQ < 1 || NUM_IRQ > 32) begin : g_bad_irq
        $error("NUM_IRQ must lie in 1..32");
    end
    if (NUM_UVAR < 1 || NUM_UVAR > 256) begin : g_bad_uvar
        $error("NUM_UVAR must lie in 1..256");
    end

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic irq;
        logic [31:0] accu;
        logic [31:0] cmd_word;
        logic [31:0] cmd_value;
        logic go;
        logic [4:0] err;
        logic gie;
        logic [31:0] ien;
        logic [7:0] vsel;
        logic [7:0] usel;
        logic [NUM_IRQ-1:0][31:0] irq_handler_bind_cmd;
        logic [NUM_UVAR-1:0][31:0] uvar;
        logic [3:0] evt;
        logic [3:0] mask;
        logic [7:0] last_stat;
        logic ap_wr;
        logic [7:0] ap_idx;
        logic [7:0] ap_motor;
        logic [31:0] ap_data;
        logic gp_wr;
        logic [7:0] gp_bank;
        logic [7:0] gp_idx;
        logic [31:0] gp_data;
        logic tx_start;
        logic [7:0] tx_stat;
        logic [7:0] tx_op;
    } aic_core_t;

    aic_core_t s_r;
    aic_core_t s_nxt;

    logic frm_valid;
    logic [63:0] frm_data;
    logic csum_ok;
    logic tx_busy;
    logic take;
    logic do_exec;
    logic host_cmd;
    aic_cmd_t cmd;
    logic [7:0] st;
    logic [4:0] clr;
    logic [3:0] evt_set;
    logic [3:0] w1c;
    logic wb_req;
    logic [31:0] rd;

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] din,
                                           input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = din[b*8 +: 8];
            end
        end
        return res;
    endfunction : wmerge

    aic_frame_rx u_rx (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_rx_valid(i_rx_valid),
        .i_rx_data(i_rx_data),
        .o_rx_ready(o_rx_ready),
        .i_take(take),
        .o_frm_valid(frm_valid),
        .o_frm_data(frm_data),
        .o_csum_ok(csum_ok)
    );

    aic_reply_tx #(.MODULE_ADDR(MODULE_ADDR), .HOST_ADDR(HOST_ADDR)) u_tx (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_start(s_r.tx_start),
        .i_stat(s_r.tx_stat),
        .i_op(s_r.tx_op),
        .i_value(`AIC_RST_WORD),
        .o_tx_valid(o_tx_valid),
        .o_tx_data(o_tx_data),
        .i_tx_ready(i_tx_ready),
        .o_busy(tx_busy)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.ap_wr = 1'b0;
        s_nxt.gp_wr = 1'b0;
        s_nxt.tx_start = 1'b0;
        take = 1'b0;
        do_exec = 1'b0;
        host_cmd = 1'b0;
        cmd = '0;
        st = `AIC_STAT_OK;
        clr = '0;
        evt_set = '0;
        w1c = '0;
        rd = `AIC_RST_WORD;
        wb_req = i_wb_cyc && i_wb_stb;

        // Host frames first, then a software-issued command
        if (frm_valid && !tx_busy && !s_r.tx_start) begin
            take = 1'b1;
            cmd = frm_data[55:0];
            if (frm_data[63:56] == MODULE_ADDR) begin
                host_cmd = 1'b1;
                do_exec = csum_ok;
                if (!csum_ok) begin
                    st = `AIC_STAT_BAD_CSUM;
                    evt_set[`AIC_EVT_CSUM] = 1'b1;
                end
            end
        end else if (s_r.go) begin
            cmd = {s_r.cmd_word[7:0], s_r.cmd_word[15:8], s_r.cmd_word[23:16], s_r.cmd_value};
            do_exec = 1'b1;
            s_nxt.go = 1'b0;
        end

        if (do_exec) begin
            case (cmd.op)
                `AIC_OP_ACCU_TO_AXIS: begin
                    s_nxt.ap_wr = 1'b1;
                    s_nxt.ap_idx = cmd.typ;
                    s_nxt.ap_motor = cmd.bank;
                    s_nxt.ap_data = s_r.accu;
                end
                `AIC_OP_ACCU_TO_GLOBAL: begin
                    if (cmd.bank == `AIC_BANK_USER) begin
                        if (32'(cmd.typ) < NUM_UVAR) begin
                            s_nxt.uvar[cmd.typ[UW-1:0]] = s_r.accu;
                        end else begin
                            st = `AIC_STAT_BAD_TYPE;
                        end
                    end else if (cmd.bank == `AIC_BANK_GLOBAL0 ||
                                 cmd.bank == `AIC_BANK_GLOBAL3) begin
                        s_nxt.gp_wr = 1'b1;
                        s_nxt.gp_bank = cmd.bank;
                        s_nxt.gp_idx = cmd.typ;
                        s_nxt.gp_data = s_r.accu;
                    end else begin
                        st = `AIC_STAT_BAD_VALUE;
                    end
                end
                `AIC_OP_CLEAR_ERR: begin
                    if (cmd.typ == `AIC_TYPE_CLEAR_ALL) begin
                        clr = '1;
                    end else if (cmd.typ <= 8'(`AIC_NUM_ERR_FLAGS)) begin
                        clr[cmd.typ[2:0] - 3'h1] = 1'b1;
                    end else begin
                        st = `AIC_STAT_BAD_TYPE;
                    end
                end
                `AIC_OP_IRQ_ENABLE, `AIC_OP_IRQ_MASK: begin
                    if (cmd.typ == `AIC_TYPE_ALL_IRQ) begin
                        s_nxt.gie = (cmd.op == `AIC_OP_IRQ_ENABLE);
                    end else if (32'(cmd.typ) < NUM_IRQ) begin
                        s_nxt.ien[cmd.typ[4:0]] = (cmd.op == `AIC_OP_IRQ_ENABLE);
                    end else begin
                        st = `AIC_STAT_BAD_TYPE;
                    end
                end
                `AIC_OP_IRQ_BIND: begin
                    if (32'(cmd.typ) < NUM_IRQ) begin
                        s_nxt.irq_handler_bind_cmd[cmd.typ[IW-1:0]] = cmd.value;
                    end else begin
                        st = `AIC_STAT_BAD_TYPE;
                    end
                end
                default: begin
                    st = `AIC_STAT_BAD_CMD;
                end
            endcase
            evt_set[`AIC_EVT_DONE] = (st == `AIC_STAT_OK);
            evt_set[`AIC_EVT_REJECT] = (st != `AIC_STAT_OK);
        end

        if (host_cmd) begin
            s_nxt.tx_start = 1'b1;
            s_nxt.tx_stat = st;
            s_nxt.tx_op = cmd.op;
        end
        if (do_exec || host_cmd) begin
            s_nxt.last_stat = st;
        end

        // Fresh error events win over a clear in the same cycle
        s_nxt.err = (s_r.err & ~clr) | i_err_set;
        evt_set[`AIC_EVT_ERR] = |(i_err_set & ~s_r.err);

        unique case (i_wb_adr)
            `AIC_REG_CTRL: rd = {31'h0000_0000, s_r.go};
            `AIC_REG_ACCU: rd = s_r.accu;
            `AIC_REG_CMD_WORD: rd = s_r.cmd_word;
            `AIC_REG_CMD_VALUE: rd = s_r.cmd_value;
            `AIC_REG_ERR_FLAGS: rd = {27'h000_0000, s_r.err};
            `AIC_REG_IRQ_GLOBAL: rd = {31'h0000_0000, s_r.gie};
            `AIC_REG_IRQ_EN: rd = s_r.ien;
            `AIC_REG_IRQ_HANDLER_BIND_CMD_SEL: rd = {24'h00_0000, s_r.vsel};
            `AIC_REG_IRQ_HANDLER_BIND_CMD_DATA: rd = (32'(s_r.vsel) < NUM_IRQ) ?
                                     s_r.irq_handler_bind_cmd[s_r.vsel[IW-1:0]] : `AIC_RST_WORD;
            `AIC_REG_UVAR_SEL: rd = {24'h00_0000, s_r.usel};
            `AIC_REG_UVAR_DATA: rd = (32'(s_r.usel) < NUM_UVAR) ?
                                     s_r.uvar[s_r.usel[UW-1:0]] : `AIC_RST_WORD;
            `AIC_REG_EVT_STATUS: rd = {28'h000_0000, s_r.evt};
            `AIC_REG_EVT_MASK: rd = {28'h000_0000, s_r.mask};
            `AIC_REG_LAST_STAT: rd = {24'h00_0000, s_r.last_stat};
            default: rd = `AIC_RST_WORD;
        endcase

        s_nxt.ack = wb_req && !s_r.ack;
        if (wb_req && !s_r.ack) begin
            s_nxt.rdat = rd;
        end
        // Writes land on the edge where the master sees ack
        if (wb_req && s_r.ack && i_wb_we) begin
            unique case (i_wb_adr)
                `AIC_REG_CTRL: begin
                    if (i_wb_sel[0] && i_wb_dat[0]) begin
                        s_nxt.go = 1'b1;
                    end
                end
                `AIC_REG_ACCU: s_nxt.accu = wmerge(s_r.accu, i_wb_dat, i_wb_sel);
                `AIC_REG_CMD_WORD: s_nxt.cmd_word = wmerge(s_r.cmd_word, i_wb_dat, i_wb_sel);
                `AIC_REG_CMD_VALUE: s_nxt.cmd_value = wmerge(s_r.cmd_value, i_wb_dat, i_wb_sel);
                `AIC_REG_IRQ_HANDLER_BIND_CMD_SEL: s_nxt.vsel = i_wb_sel[0] ? i_wb_dat[7:0] : s_r.vsel;
                `AIC_REG_UVAR_SEL: s_nxt.usel = i_wb_sel[0] ? i_wb_dat[7:0] : s_r.usel;
                `AIC_REG_EVT_STATUS: w1c = i_wb_sel[0] ? i_wb_dat[3:0] : 4'h0;
                `AIC_REG_EVT_MASK: s_nxt.mask = i_wb_sel[0] ? i_wb_dat[3:0] : s_r.mask;
                default: begin
                end
            endcase
        end
        s_nxt.evt = (s_r.evt & ~w1c) | evt_set;
        s_nxt.irq = |(s_nxt.evt & s_nxt.mask);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_wb_ack = s_r.ack;
    assign o_wb_dat = s_r.rdat;
    assign o_ap_wr = s_r.ap_wr;
    assign o_ap_idx = s_r.ap_idx;
    assign o_ap_motor = s_r.ap_motor;
    assign o_ap_data = s_r.ap_data;
    assign o_gp_wr = s_r.gp_wr;
    assign o_gp_bank = s_r.gp_bank;
    assign o_gp_idx = s_r.gp_idx;
    assign o_gp_data = s_r.gp_data;
    assign o_irq = s_r.irq;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);

    AST_AXIS_COPY: assert property (
        (do_exec && cmd.op == `AIC_OP_ACCU_TO_AXIS) |=>
        (o_ap_wr && o_ap_data == $past(s_r.accu) && o_ap_idx == $past(cmd.typ)))
        else $error("axis copy did not carry the accumulator");
    AST_GLOBAL_COPY: assert property (
        (do_exec && cmd.op == `AIC_OP_ACCU_TO_GLOBAL && cmd.bank == `AIC_BANK_GLOBAL3) |=>
        (o_gp_wr && o_gp_bank == `AIC_BANK_GLOBAL3 ##1 !o_gp_wr))
        else $error("global copy strobe wrong");
    AST_USER_VAR: assert property (
        (do_exec && cmd.op == `AIC_OP_ACCU_TO_GLOBAL && cmd.bank == `AIC_BANK_USER &&
         32'(cmd.typ) < NUM_UVAR) |=>
        (s_r.uvar[$past(cmd.typ[UW-1:0])] == $past(s_r.accu) && !o_gp_wr))
        else $error("user variable not stored");
    AST_REPLY_OK: assert property (
        (host_cmd && st == `AIC_STAT_OK) |=> (s_r.tx_start && s_r.tx_stat == 8'h64)
        ##1 o_tx_valid)
        else $error("success reply not issued");
    AST_CLEAR_ALL: assert property (
        (do_exec && cmd.op == `AIC_OP_CLEAR_ERR && cmd.typ == 8'h00 && i_err_set == 5'h00)
        |=> (s_r.err == 5'h00))
        else $error("clear-all left a flag set");
    AST_CLEAR_ONE: assert property (
        (do_exec && cmd.op == `AIC_OP_CLEAR_ERR && cmd.typ == 8'h04 && !i_err_set[3]) |=>
        (!s_r.err[3] && s_r.err[2:0] == $past(s_r.err[2:0] | i_err_set[2:0])))
        else $error("position flag clear wrong");
    AST_IRQ_ON: assert property (
        (do_exec && cmd.op == `AIC_OP_IRQ_ENABLE && 32'(cmd.typ) < NUM_IRQ) |=>
        (s_r.ien[$past(cmd.typ[4:0])] && $stable(s_r.gie)))
        else $error("interrupt enable not set");
    AST_GIE_ON: assert property (
        (do_exec && cmd.op == `AIC_OP_IRQ_ENABLE && cmd.typ == 8'hFF) |=>
        (s_r.gie && $stable(s_r.ien)))
        else $error("global enable not set");
    AST_IRQ_OFF: assert property (
        (do_exec && cmd.op == `AIC_OP_IRQ_MASK && 32'(cmd.typ) < NUM_IRQ) |=>
        !s_r.ien[$past(cmd.typ[4:0])])
        else $error("interrupt enable not cleared");
    AST_GIE_OFF: assert property (
        (do_exec && cmd.op == `AIC_OP_IRQ_MASK && cmd.typ == 8'hFF) |=> !s_r.gie)
        else $error("global enable not cleared");
    AST_IRQ_HANDLER_BIND_CMD_STORE: assert property (
        (do_exec && cmd.op == `AIC_OP_IRQ_BIND && 32'(cmd.typ) < NUM_IRQ) |=>
        (s_r.irq_handler_bind_cmd[$past(cmd.typ[IW-1:0])] == $past(cmd.value)))
        else $error("handler address not replaced");
    AST_BAD_CSUM: assert property (
        (take && frm_data[63:56] == MODULE_ADDR && !csum_ok) |=>
        (s_r.tx_start && s_r.tx_stat == 8'h01 && s_r.evt[1]))
        else $error("bad checksum not reported");

    COV_AXIS: cover property (do_exec && cmd.op == `AIC_OP_ACCU_TO_AXIS ##1 o_ap_wr);
    COV_USER: cover property (do_exec && cmd.bank == `AIC_BANK_USER && st == `AIC_STAT_OK);
    COV_REBIND: cover property (do_exec && cmd.op == `AIC_OP_IRQ_BIND ##[1:40]
        do_exec && cmd.op == `AIC_OP_IRQ_BIND);
    COV_CSUM: cover property (take && !csum_ok);

endmodule : aic_cmd_exec

// ===== verification/aic_host_model.sv
// Host model: sends command frames, collects replies
`timescale 1ns/1ps
module aic_host_model (
    input wire logic i_ref_clk,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    input wire logic i_rx_ready,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready,
    output logic [71:0] o_rep,
    output logic o_rep_done
);
    logic [3:0] cnt_r = 4'h0;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
        o_tx_ready = 1'b0;
        o_rep = 72'h0;
        o_rep_done = 1'b0;
    end
    // Reply bytes shifted in, with random stalls
    always @(posedge i_ref_clk) begin
        o_tx_ready <= 1'($urandom % 2);
        o_rep_done <= i_tx_valid && o_tx_ready && cnt_r == 4'h8;
        if (i_tx_valid && o_tx_ready) begin
            o_rep <= {o_rep[63:0], i_tx_data};
            cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
        end
    end
    task automatic send(input logic [63:0] hdr, input logic bad);
        logic [7:0] sum;
        sum = 8'h00;
        for (int k = 0; k < 8; k++) sum += hdr[k*8 +: 8];
        @(posedge i_ref_clk);
        for (int k = 0; k < 9; k++) begin
            o_rx_valid <= 1'b1;
            o_rx_data <= (k < 8) ? hdr[63-k*8 -: 8] : (bad ? ~sum : sum);
            do @(posedge i_ref_clk); while (i_rx_ready !== 1'b1);
        end
        o_rx_valid <= 1'b0;
        o_rx_data <= bad ? sum : ~sum;
    endtask : send
endmodule : aic_host_model

// ===== verification/tb_aic_cmd_exec.sv
// Testbench for the command executor
`timescale 1ns/1ps
`include "aic_params.svh"
module tb_aic_cmd_exec;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00, rxd, txd, t, i, api, apm, gpb, gpi;
    logic [31:0] wdat = 32'h0, rdat, q, acc, v, apd, gpd;
    logic [4:0] err_set = 5'h00, f;
    logic rxv, rxr, txv, txr, ack, irq, apw, gpw, done;
    logic [71:0] rep;
    logic [15:0] exp_rep [$];
    logic [56:0] exp_pw [$];
    int mismatches = 0, total_checks = 0;
    initial forever #20 clk = ~clk;
    aic_cmd_exec aic_cmd_exec_i (.i_ref_clk(clk), .i_reset(rst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_rx_valid(rxv), .i_rx_data(rxd),
        .o_rx_ready(rxr), .o_tx_valid(txv), .o_tx_data(txd), .i_tx_ready(txr),
        .i_err_set(err_set), .o_ap_wr(apw), .o_ap_idx(api), .o_ap_motor(apm),
        .o_ap_data(apd), .o_gp_wr(gpw), .o_gp_bank(gpb), .o_gp_idx(gpi),
        .o_gp_data(gpd), .o_irq(irq));
    aic_host_model aic_host_model_i (.i_ref_clk(clk), .o_rx_valid(rxv), .o_rx_data(rxd),
        .i_rx_ready(rxr), .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(txr),
        .o_rep(rep), .o_rep_done(done));
    task automatic check(input string nm, input logic [71:0] seen, input logic [71:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Watches replies and parameter writes against the noted expectations
    always @(posedge clk) begin
        logic [7:0] s;
        s = 8'h00;
        for (int k = 1; k < 9; k++) s += rep[k*8 +: 8];
        if (done) check("reply", rep, {8'h01, 8'h02, exp_rep.pop_front(), 32'h0, s});
        if (apw) check("axis", {api, apm, apd}, exp_pw.pop_front());
        if (gpw) check("global", {1'b1, gpb, gpi, gpd}, exp_pw.pop_front());
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        check(nm, r, e);
    endtask : rd
    task automatic cmd(input logic [7:0] op, input logic [7:0] ty, input logic [7:0] bk,
                       input logic [31:0] va, input logic [7:0] st, input logic bad);
        exp_rep.push_back({st, op});
        aic_host_model_i.send({8'h01, op, ty, bk, va}, bad);
        while (exp_rep.size() != 0) @(posedge clk);
    endtask : cmd
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report();
    end
    initial begin
        void'($urandom(49977));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        acc = $urandom;
        v = $urandom;
        t = 8'($urandom % 64);
        wb(1'b1, `AIC_REG_ACCU, acc, q);
        rd("accu", `AIC_REG_ACCU, acc);
        rd("unmapped", 8'hFC, 32'h0);
        exp_pw.push_back({t, ~t, acc});
        cmd(`AIC_OP_ACCU_TO_AXIS, t, ~t, v, `AIC_STAT_OK, 1'b0);
        exp_pw.push_back({1'b1, 8'h00, t, acc});
        cmd(`AIC_OP_ACCU_TO_GLOBAL, t, `AIC_BANK_GLOBAL0, v, `AIC_STAT_OK, 1'b0);
        exp_pw.push_back({1'b1, 8'h03, t, acc});
        cmd(`AIC_OP_ACCU_TO_GLOBAL, t, `AIC_BANK_GLOBAL3, v, `AIC_STAT_OK, 1'b0);
        cmd(`AIC_OP_ACCU_TO_GLOBAL, t, `AIC_BANK_USER, v, `AIC_STAT_OK, 1'b0);
        wb(1'b1, `AIC_REG_UVAR_SEL, {24'h0, t}, q);
        rd("uvar", `AIC_REG_UVAR_DATA, acc);
        cmd(`AIC_OP_ACCU_TO_GLOBAL, t, 8'h01, v, `AIC_STAT_BAD_VALUE, 1'b0);
        cmd(`AIC_OP_ACCU_TO_AXIS, t, t, v, `AIC_STAT_BAD_CSUM, 1'b1);
        rd("last_stat", `AIC_REG_LAST_STAT, {24'h0, `AIC_STAT_BAD_CSUM});
        cmd(8'h30, t, t, v, `AIC_STAT_BAD_CMD, 1'b0);
        cmd(`AIC_OP_CLEAR_ERR, 8'h06, t, v, `AIC_STAT_BAD_TYPE, 1'b0);
        f = 5'h1F;
        for (int k = 0; k < 7; k++) begin
            @(posedge clk);
            err_set <= (k < 2 || k == 6) ? 5'h1F : 5'h00;
            @(posedge clk);
            err_set <= 5'h00;
            cmd(`AIC_OP_CLEAR_ERR, 8'(k % 6), 8'h00, v, `AIC_STAT_OK, 1'b0);
            if (k > 0 && k < 6) f[k-1] = 1'b0;
            rd("err_flags", `AIC_REG_ERR_FLAGS, (k % 6 == 0) ? 32'h0 : {27'h0, f});
        end
        i = 8'($urandom % 32);
        cmd(`AIC_OP_IRQ_ENABLE, i, ~t, v, `AIC_STAT_OK, 1'b0);
        rd("irq_en", `AIC_REG_IRQ_EN, 32'h1 << i);
        cmd(`AIC_OP_IRQ_ENABLE, `AIC_TYPE_ALL_IRQ, t, v, `AIC_STAT_OK, 1'b0);
        rd("irq_glb", `AIC_REG_IRQ_GLOBAL, 32'h1);
        cmd(`AIC_OP_IRQ_MASK, i, t, v, `AIC_STAT_OK, 1'b0);
        rd("irq_dis", `AIC_REG_IRQ_EN, 32'h0);
        cmd(`AIC_OP_IRQ_MASK, `AIC_TYPE_ALL_IRQ, t, v, `AIC_STAT_OK, 1'b0);
        rd("glb_off", `AIC_REG_IRQ_GLOBAL, 32'h0);
        wb(1'b1, `AIC_REG_IRQ_HANDLER_BIND_CMD_SEL, {24'h0, i}, q);
        repeat (2) begin
            v = $urandom;
            wb(1'b1, `AIC_REG_CMD_VALUE, v, q);
            wb(1'b1, `AIC_REG_CMD_WORD, {8'h00, 8'h00, i, `AIC_OP_IRQ_BIND}, q);
            wb(1'b1, `AIC_REG_CTRL, 32'h1, q);
            rd("vector", `AIC_REG_IRQ_HANDLER_BIND_CMD_DATA, v);
        end
        // Frame for another module: no reply may appear
        aic_host_model_i.send({8'h05, `AIC_OP_IRQ_ENABLE, i, 8'h00, acc}, 1'b0);
        repeat (60) @(posedge clk);
        rd("irq_handler_bind_cmd_kept", `AIC_REG_IRQ_HANDLER_BIND_CMD_DATA, v);
        rd("foreign", `AIC_REG_IRQ_EN, 32'h0);
        wb(1'b1, `AIC_REG_EVT_STATUS, 32'hF, q);
        cmd(`AIC_OP_IRQ_ENABLE, i, 8'h00, v, `AIC_STAT_OK, 1'b0);
        rd("evt", `AIC_REG_EVT_STATUS, 32'h1);
        check("irq_masked", irq, 72'h0);
        wb(1'b1, `AIC_REG_EVT_MASK, 32'h1, q);
        repeat (2) @(posedge clk);
        check("irq_on", irq, 72'h1);
        wb(1'b1, `AIC_REG_EVT_STATUS, 32'h1, q);
        repeat (2) @(posedge clk);
        check("irq_off", irq, 72'h0);
        final_report();
    end
endmodule : tb_aic_cmd_exec
